/* File: gpt_regs.vh */
// gpt_regs.vh: register offsets, field positions, reset values and timing counts
// assumes: included by the timer unit design file, APB byte addresses, 32-bit words
`ifndef GPT_REGS_VH
`define GPT_REGS_VH
// register byte offsets
`define GPT_CTL_LOW 12'h000
`define GPT_CTL_CORE 12'h004
`define GPT_CTL_HIGH 12'h008
`define GPT_CTL_SAUX 12'h00C
`define GPT_CTL_SCORE 12'h010
`define GPT_CNT_LOW 12'h020
`define GPT_CNT_CORE 12'h024
`define GPT_CNT_HIGH 12'h028
`define GPT_CNT_SAUX 12'h02C
`define GPT_CNT_SCORE 12'h030
`define GPT_CAPTURE_RELOAD_REG 12'h034
`define GPT_FLAGS 12'h040
`define GPT_STATUS 12'h044
// control word fields
`define GPT_F_RUN 0
`define GPT_F_MODE_LO 1
`define GPT_F_MODE_HI 3
`define GPT_F_DOWN 4
`define GPT_F_EXTDIR 5
`define GPT_F_PRE_LO 6
`define GPT_F_PRE_HI 8
`define GPT_F_OUTEN 9
`define GPT_F_EDGE_LO 10
`define GPT_F_EDGE_HI 11
`define GPT_F_CLR 12
`define GPT_F_REL 13
// mode codes
`define GPT_MODE_TIMER 3'h0
`define GPT_MODE_COUNT 3'h1
`define GPT_MODE_GATE 3'h2
`define GPT_MODE_GATEN 3'h3
`define GPT_MODE_CONCAT 3'h4
`define GPT_MODE_RELOAD 3'h5
`define GPT_MODE_CAPTURE 3'h6
// reset values
`define GPT_CTL_RESET 16'h0000
`define GPT_CNT_RESET 16'h0000
// timing: fastest count periods at the reference clock
`define GPT_REF_MHZ 20
`define GPT_M1_RES_NS 400
`define GPT_M2_RES_NS 160
`define GPT_CLK_NS 8
`define GPT_M1_BASE ((`GPT_M1_RES_NS + `GPT_CLK_NS - 1) / `GPT_CLK_NS)
`define GPT_M2_BASE ((`GPT_M2_RES_NS + `GPT_CLK_NS - 1) / `GPT_CLK_NS)
`endif

/* File: gpt_unit.v */
// gpt_unit.v: general purpose timer unit, two modules, five 16-bit up/down timers
// assumes: one 125 MHz clock, APB slave port, external pins asynchronous
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "gpt_regs.vh"
module gpt_unit #(
    parameter integer M1_BASE = `GPT_M1_BASE,
    parameter integer M2_BASE = `GPT_M2_BASE
) (
    input wire SYS_CLK_IN,
    input wire SRST_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output reg [31:0] PRDATA_OUT,
    output reg PREADY_OUT,
    output reg PSLVERR_OUT,
    input wire [4:0] TIMER_INPUT_PIN_IN,
    input wire [4:0] DIRECTION_PIN_IN,
    input wire CAPTURE_INPUT_PIN_IN,
    output reg CORE_TOGGLE_OUT,
    output reg HIGH_TOGGLE_OUT,
    output reg SECOND_TOGGLE_OUT,
    output reg COMPARE_UNIT_CLOCK_OUT,
    output reg [5:0] FLAGS_OUT
);
    // timer index: 0 aux low, 1 core, 2 aux high, 3 second aux, 4 second core
    localparam NT = 5;
    // apb handshake states, one-hot
    localparam ST_IDLE = 2'b01;
    localparam ST_DONE = 2'b10;

    reg [15:0] ctl [0:NT-1];
    reg [15:0] cnt [0:NT-1];
    reg [15:0] capture_reload_reg;
    reg [5:0] flags;
    reg [1:0] apb_state;
    reg [2:0] sync_t [0:NT-1];
    reg [2:0] sync_d [0:NT-1];
    reg [2:0] sync_c;
    reg [NT-1:0] pin_lvl;
    reg [NT-1:0] dir_lvl;
    reg cap_lvl;
    reg [7:0] base1;
    reg [7:0] base2;
    reg [7:0] pre [0:NT-1];
    reg core_otl;
    reg high_otl;
    reg second_otl;
    reg core_otl_d;
    reg high_otl_d;
    reg second_otl_d;

    // pin edges and levels after three-stage synchronisation
    wire [NT-1:0] pin_rise;
    wire [NT-1:0] pin_fall;
    // an edge counts once the second and third stages agree on a new level,
    // so a pulse shorter than two clocks is dropped rather than counted;
    // levels reset low like the idle pins, so reset makes no false edge
    wire cap_rise = sync_c[2] & sync_c[1] & ~cap_lvl;
    wire cap_fall = ~sync_c[2] & ~sync_c[1] & cap_lvl;
    wire base1_tick = (base1 == 8'h00);
    wire base2_tick = (base2 == 8'h00);
    wire [NT-1:0] tick;
    wire [NT-1:0] dn;
    wire [NT-1:0] ovf;
    wire [NT-1:0] step;
    wire core_otl_rise = core_otl & ~core_otl_d;
    wire core_otl_fall = ~core_otl & core_otl_d;
    wire second_otl_edge = second_otl ^ second_otl_d;
    // a write lands once per transfer, in the first access cycle
    wire wr = PSEL_IN & PENABLE_IN & PWRITE_IN & (apb_state == ST_IDLE);

    // base dividers: fastest count rate of each module
    // periods are whole clocks of this design, rounded up, so a timer
    // outside counter mode never counts faster than its module's fastest rate
    always @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            base1 <= 8'h00;
            base2 <= 8'h00;
        end else begin
            base1 <= base1_tick ? M1_BASE[7:0] - 8'h01 : base1 - 8'h01;
            base2 <= base2_tick ? M2_BASE[7:0] - 8'h01 : base2 - 8'h01;
        end
    end

    // synchronisers for the capture pin
    always @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            sync_c <= 3'h0;
            cap_lvl <= 1'b0;
        end else begin
            sync_c <= {sync_c[1:0], CAPTURE_INPUT_PIN_IN};
            if (sync_c[2] == sync_c[1]) begin
                cap_lvl <= sync_c[2];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NT; g = g + 1) begin : g_tmr
            wire [2:0] mode = ctl[g][`GPT_F_MODE_HI:`GPT_F_MODE_LO];
            wire [2:0] psel = ctl[g][`GPT_F_PRE_HI:`GPT_F_PRE_LO];
            wire [1:0] edg = ctl[g][`GPT_F_EDGE_HI:`GPT_F_EDGE_LO];
            wire base_t = (g < 3) ? base1_tick : base2_tick;
            // prescaler divides the base tick by a power of two
            wire pre_t = base_t & ((pre[g] & ((8'h01 << psel) - 8'h01)) == 8'h00);
            wire pin_ev = (edg[0] & pin_rise[g]) | (edg[1] & pin_fall[g]);
            wire concat_ev;
            if (g == 0 || g == 2) begin : g_cat
                // aux timers of module one count core latch transitions
                assign concat_ev = core_otl ^ core_otl_d;
            end else if (g == 3) begin : g_cat
                // second aux counts both edges of the second latch
                assign concat_ev = second_otl_edge;
            end else begin : g_cat
                assign concat_ev = 1'b0;
            end
            assign pin_rise[g] = sync_t[g][2] & sync_t[g][1] & ~pin_lvl[g];
            assign pin_fall[g] = ~sync_t[g][2] & ~sync_t[g][1] & pin_lvl[g];
            // count event by mode
            // reload and capture modes hold the timer still
            assign tick[g] = ~ctl[g][`GPT_F_RUN] ? 1'b0 :
                (mode == `GPT_MODE_TIMER) ? pre_t :
                (mode == `GPT_MODE_COUNT) ? pin_ev :
                (mode == `GPT_MODE_GATE) ? (pre_t & pin_lvl[g]) :
                (mode == `GPT_MODE_GATEN) ? (pre_t & ~pin_lvl[g]) :
                (mode == `GPT_MODE_CONCAT) ? concat_ev :
                1'b0;
            // direction from software, optionally inverted by the pin
            assign dn[g] = ctl[g][`GPT_F_DOWN] ^ (ctl[g][`GPT_F_EXTDIR] & dir_lvl[g]);
            assign ovf[g] = tick[g] & (dn[g] ? (cnt[g] == 16'h0000) : (cnt[g] == 16'hFFFF));
            assign step[g] = tick[g];

            // per-timer synchronisers and prescaler
            always @(posedge SYS_CLK_IN) begin
                if (SRST_IN) begin
                    sync_t[g] <= 3'h0;
                    sync_d[g] <= 3'h0;
                    pin_lvl[g] <= 1'b0;
                    dir_lvl[g] <= 1'b0;
                    pre[g] <= 8'h00;
                end else begin
                    sync_t[g] <= {sync_t[g][1:0], TIMER_INPUT_PIN_IN[g]};
                    sync_d[g] <= {sync_d[g][1:0], DIRECTION_PIN_IN[g]};
                    if (sync_t[g][2] == sync_t[g][1]) begin
                        pin_lvl[g] <= sync_t[g][2];
                    end
                    if (sync_d[g][2] == sync_d[g][1]) begin
                        dir_lvl[g] <= sync_d[g][2];
                    end
                    if (base_t) begin
                        pre[g] <= pre[g] + 8'h01;
                    end
                end
            end
        end
    endgenerate

    // reload / capture decisions for the core timer and the second module
    wire low_rel = (ctl[0][`GPT_F_MODE_HI:`GPT_F_MODE_LO] == `GPT_MODE_RELOAD);
    wire high_rel = (ctl[2][`GPT_F_MODE_HI:`GPT_F_MODE_LO] == `GPT_MODE_RELOAD);
    wire low_cap = (ctl[0][`GPT_F_MODE_HI:`GPT_F_MODE_LO] == `GPT_MODE_CAPTURE);
    wire high_cap = (ctl[2][`GPT_F_MODE_HI:`GPT_F_MODE_LO] == `GPT_MODE_CAPTURE);
    // edge field of an aux in reload mode: bit0 pin rise, bit1 latch rise, both latch fall
    wire low_trig = low_rel & (ctl[0][`GPT_F_EDGE_HI:`GPT_F_EDGE_LO] == 2'b01 ? pin_rise[0] :
        ctl[0][`GPT_F_EDGE_HI:`GPT_F_EDGE_LO] == 2'b10 ? core_otl_rise :
        ctl[0][`GPT_F_EDGE_HI:`GPT_F_EDGE_LO] == 2'b11 ? core_otl_fall : 1'b0);
    wire high_trig = high_rel & (ctl[2][`GPT_F_EDGE_HI:`GPT_F_EDGE_LO] == 2'b01 ? pin_rise[2] :
        ctl[2][`GPT_F_EDGE_HI:`GPT_F_EDGE_LO] == 2'b10 ? core_otl_rise :
        ctl[2][`GPT_F_EDGE_HI:`GPT_F_EDGE_LO] == 2'b11 ? core_otl_fall : 1'b0);
    wire low_capev = low_cap & (pin_rise[0] | pin_fall[0]) &
        ((ctl[0][`GPT_F_EDGE_LO] & pin_rise[0]) | (ctl[0][`GPT_F_EDGE_HI] & pin_fall[0]));
    wire high_capev = high_cap & (pin_rise[2] | pin_fall[2]) &
        ((ctl[2][`GPT_F_EDGE_LO] & pin_rise[2]) | (ctl[2][`GPT_F_EDGE_HI] & pin_fall[2]));
    wire cr_ev = (ctl[3][`GPT_F_EDGE_LO] & cap_rise) | (ctl[3][`GPT_F_EDGE_HI] & cap_fall);
    wire score_rel = ctl[4][`GPT_F_REL] & ovf[4];

    // counters, toggle latches, capture/reload register
    integer i;
    always @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            for (i = 0; i < NT; i = i + 1) begin
                cnt[i] <= `GPT_CNT_RESET;
            end
            capture_reload_reg <= `GPT_CNT_RESET;
            core_otl <= 1'b0;
            high_otl <= 1'b0;
            second_otl <= 1'b0;
            core_otl_d <= 1'b0;
            high_otl_d <= 1'b0;
            second_otl_d <= 1'b0;
        end else begin
            // delayed latches give one-cycle edge pulses for reload and concat
            core_otl_d <= core_otl;
            high_otl_d <= high_otl;
            second_otl_d <= second_otl;
            for (i = 0; i < NT; i = i + 1) begin
                if (step[i]) begin
                    cnt[i] <= dn[i] ? cnt[i] - 16'h0001 : cnt[i] + 16'h0001;
                end
            end
            if (ovf[1]) begin
                core_otl <= ~core_otl;
            end
            if (ovf[2]) begin
                high_otl <= ~high_otl;
            end
            if (ovf[4]) begin
                second_otl <= ~second_otl;
            end
            // low reload wins over high when both fire; opposite edges alternate
            if (low_trig) begin
                cnt[1] <= cnt[0];
            end else if (high_trig) begin
                cnt[1] <= cnt[2];
            end
            if (low_capev) begin
                cnt[0] <= cnt[1];
            end
            if (high_capev) begin
                cnt[2] <= cnt[1];
            end
            if (score_rel) begin
                cnt[4] <= capture_reload_reg;
            end
            if (cr_ev) begin
                capture_reload_reg <= cnt[3];
                if (ctl[3][`GPT_F_CLR]) begin
                    cnt[3] <= `GPT_CNT_RESET;
                end
            end
            // software writes to counters override hardware in that cycle
            // so a value software writes is never lost to a tick
            if (wr) begin
                for (i = 0; i < NT; i = i + 1) begin
                    if (PADDR_IN == `GPT_CNT_LOW + i * 4) begin
                        cnt[i] <= PWDATA_IN[15:0];
                    end
                end
                if (PADDR_IN == `GPT_CAPTURE_RELOAD_REG) begin
                    capture_reload_reg <= PWDATA_IN[15:0];
                end
            end
        end
    end

    // control registers and sticky event flags
    // a control write takes effect in the cycle after the access
    always @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            for (i = 0; i < NT; i = i + 1) begin
                ctl[i] <= `GPT_CTL_RESET;
            end
            flags <= 6'h00;
        end else begin
            if (wr) begin
                for (i = 0; i < NT; i = i + 1) begin
                    if (PADDR_IN == `GPT_CTL_LOW + i * 4) begin
                        ctl[i] <= PWDATA_IN[15:0];
                    end
                end
            end
            // flag bits: 0 to 4 timer wraps, 5 capture into capture_reload_reg
            // write one to clear; a new event in the same cycle wins
            flags <= ((wr && PADDR_IN == `GPT_FLAGS) ? (flags & ~PWDATA_IN[5:0]) : flags)
                | {cr_ev, ovf};
        end
    end

    // outputs: toggle pins, compare clock, flags
    always @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            CORE_TOGGLE_OUT <= 1'b0;
            HIGH_TOGGLE_OUT <= 1'b0;
            SECOND_TOGGLE_OUT <= 1'b0;
            COMPARE_UNIT_CLOCK_OUT <= 1'b0;
            FLAGS_OUT <= 6'h00;
        end else begin
            // a toggle pin shows its latch only while output is enabled
            CORE_TOGGLE_OUT <= core_otl & ctl[1][`GPT_F_OUTEN];
            HIGH_TOGGLE_OUT <= high_otl & ctl[2][`GPT_F_OUTEN];
            SECOND_TOGGLE_OUT <= second_otl & ctl[4][`GPT_F_OUTEN];
            // one-cycle pulse per second core wrap
            COMPARE_UNIT_CLOCK_OUT <= ovf[4];
            FLAGS_OUT <= flags;
        end
    end

    // apb slave: one wait state, reads mux registers
    // ready follows the first access cycle by one clock
    // unmapped offsets answer with an error and zero data, writes ignored
    always @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            apb_state <= ST_IDLE;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h00000000;
        end else begin
            case (apb_state)
                ST_IDLE: begin
                    PREADY_OUT <= 1'b0;
                    PSLVERR_OUT <= 1'b0;
                    if (PSEL_IN && PENABLE_IN) begin
                        apb_state <= ST_DONE;
                        PREADY_OUT <= 1'b1;
                        PRDATA_OUT <= 32'h00000000;
                        PSLVERR_OUT <= 1'b1;
                        for (i = 0; i < NT; i = i + 1) begin
                            if (PADDR_IN == `GPT_CTL_LOW + i * 4) begin
                                PRDATA_OUT <= {16'h0000, ctl[i]};
                                PSLVERR_OUT <= 1'b0;
                            end
                            if (PADDR_IN == `GPT_CNT_LOW + i * 4) begin
                                PRDATA_OUT <= {16'h0000, cnt[i]};
                                PSLVERR_OUT <= 1'b0;
                            end
                        end
                        if (PADDR_IN == `GPT_CAPTURE_RELOAD_REG) begin
                            PRDATA_OUT <= {16'h0000, capture_reload_reg};
                            PSLVERR_OUT <= 1'b0;
                        end
                        if (PADDR_IN == `GPT_FLAGS) begin
                            PRDATA_OUT <= {26'h0000000, flags};
                            PSLVERR_OUT <= 1'b0;
                        end
                        if (PADDR_IN == `GPT_STATUS) begin
                            PRDATA_OUT <= {29'h00000000, second_otl, high_otl, core_otl};
                            PSLVERR_OUT <= 1'b0;
                        end
                    end
                end
                ST_DONE: begin
                    apb_state <= ST_IDLE;
                    PREADY_OUT <= 1'b0;
                    PSLVERR_OUT <= 1'b0;
                end
                default: begin
                    apb_state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: gpt_monitor.sv */
// gpt_monitor.sv: port assertions for the timer unit
// assumes: bound into gpt_unit, one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module gpt_monitor #(
    parameter integer M1_BASE = 50,
    parameter integer M2_BASE = 20
) (
    input wire logic SYS_CLK_IN,
    input wire logic SRST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic [4:0] TIMER_INPUT_PIN_IN,
    input wire logic [4:0] DIRECTION_PIN_IN,
    input wire logic CAPTURE_INPUT_PIN_IN,
    input wire logic CORE_TOGGLE_OUT,
    input wire logic HIGH_TOGGLE_OUT,
    input wire logic SECOND_TOGGLE_OUT,
    input wire logic COMPARE_UNIT_CLOCK_OUT,
    input wire logic [5:0] FLAGS_OUT
);
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (SRST_IN);
    // flag clear write seen on the bus
    wire wr_flg = PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == 12'h040;
    // bus phases
    sequence s_setup;
        PSEL_IN && !PENABLE_IN;
    endsequence
    sequence s_access;
        PSEL_IN && PENABLE_IN;
    endsequence
    property p_answer;
        s_setup ##1 s_access |=> PREADY_OUT;
    endproperty
    a_answer: assert property (p_answer) else $error("ready missing after access");
    property p_ready_pulse;
        PREADY_OUT |=> !PREADY_OUT;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    property p_ready_cause;
        $rose(PREADY_OUT) |-> $past(PSEL_IN && PENABLE_IN);
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
    property p_err;
        PSLVERR_OUT |-> PREADY_OUT;
    endproperty
    a_err: assert property (p_err) else $error("slave error without ready");
    property p_upper;
        PREADY_OUT && !PWRITE_IN |-> PRDATA_OUT[31:16] == 16'h0000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read half not zero");
    property p_cmp_pulse;
        COMPARE_UNIT_CLOCK_OUT |=> !COMPARE_UNIT_CLOCK_OUT;
    endproperty
    a_cmp_pulse: assert property (p_cmp_pulse) else $error("compare clock too long");
    property p_cmp_flag;
        COMPARE_UNIT_CLOCK_OUT |-> ##[0:2] FLAGS_OUT[4];
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) else $error("overflow flag not set");
    property p_sticky;
        (|($past(FLAGS_OUT) & ~FLAGS_OUT)) |-> ($past(wr_flg, 2) || $past(wr_flg, 3));
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag fell without clear");
endmodule
bind gpt_unit gpt_monitor #(.M1_BASE(M1_BASE), .M2_BASE(M2_BASE)) gpt_monitor_i (
    .SYS_CLK_IN(SYS_CLK_IN), .SRST_IN(SRST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
    .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .TIMER_INPUT_PIN_IN(TIMER_INPUT_PIN_IN), .DIRECTION_PIN_IN(DIRECTION_PIN_IN),
    .CAPTURE_INPUT_PIN_IN(CAPTURE_INPUT_PIN_IN), .CORE_TOGGLE_OUT(CORE_TOGGLE_OUT),
    .HIGH_TOGGLE_OUT(HIGH_TOGGLE_OUT), .SECOND_TOGGLE_OUT(SECOND_TOGGLE_OUT),
    .COMPARE_UNIT_CLOCK_OUT(COMPARE_UNIT_CLOCK_OUT), .FLAGS_OUT(FLAGS_OUT));
`default_nettype wire

/* File: gpt_pins.sv */
// gpt_pins.sv: model of the external gate, count, direction and capture pins
// assumes: tasks called by the testbench right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module gpt_pins (
    input wire logic clk_in,
    output var logic [4:0] tin_out,
    output var logic [4:0] dir_out,
    output var logic cap_out
);
    // all pins idle low
    initial begin
        tin_out = 5'h00;
        dir_out = 5'h00;
        cap_out = 1'b0;
    end
    // index five is the capture pin
    task set_pin(input int idx, input logic v);
        if (idx == 5) cap_out <= v;
        else tin_out[idx] <= v;
    endtask
    task set_dir(input int idx, input logic v);
        dir_out[idx] <= v;
    endtask
    // levels held four cycles so the input synchroniser sees each one
    task pulse(input int idx, input int n);
        repeat (n) begin
            repeat (4) @(posedge clk_in);
            set_pin(idx, 1'b1);
            repeat (4) @(posedge clk_in);
            set_pin(idx, 1'b0);
        end
    endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// testbench.sv: register-level tests of the timer unit
// assumes: gpt_unit at default rates, gpt_pins on its pins, gpt_monitor bound
`timescale 1ns/1ps
`default_nettype none
`include "gpt_regs.vh"
module testbench;
    logic clk, srst, psel, pen, pwr, prdy, perr, ct, ht, st, cmp, er, cap;
    logic [11:0] pa;
    logic [31:0] pwd, prd, rv;
    logic [5:0] flg;
    logic [4:0] tin, dir;
    int miscompares, compares, n;
    localparam logic [31:0] RUN = 32'h0001, DN = 32'h0010, XD = 32'h0020, OE = 32'h0200;
    localparam logic [31:0] CL = 32'h1000, RL = 32'h2000;
    gpt_unit gpt_unit_i (.SYS_CLK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
        .PSLVERR_OUT(perr), .TIMER_INPUT_PIN_IN(tin), .DIRECTION_PIN_IN(dir),
        .CAPTURE_INPUT_PIN_IN(cap), .CORE_TOGGLE_OUT(ct), .HIGH_TOGGLE_OUT(ht),
        .SECOND_TOGGLE_OUT(st), .COMPARE_UNIT_CLOCK_OUT(cmp), .FLAGS_OUT(flg));
    gpt_pins gpt_pins_i (.clk_in(clk), .tin_out(tin), .dir_out(dir), .cap_out(cap));
    // 125 MHz clock
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    task summarize;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    // one bus transfer, held until ready is sampled
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            summarize;
        end else begin
            {rv, er} = {prd, perr};
            {psel, pen} <= 2'b00;
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(nm, rv, e);
    endtask
    task rng(input string nm, input logic [11:0] a, input logic [31:0] lo, input logic [31:0] hi);
        apb(0, a, 0);
        chk(nm, 32'(rv >= lo && rv <= hi), 32'h1);
    endtask
    function logic [31:0] cw(input logic [2:0] m, input logic [2:0] p, input logic [1:0] e);
        return (32'(m) << `GPT_F_MODE_LO) | (32'(p) << `GPT_F_PRE_LO) | (32'(e) << `GPT_F_EDGE_LO);
    endfunction
    // run a timer for a 1000-cycle window, then read its count
    task rate(input string nm, input logic [11:0] c, input logic [11:0] k, input logic [31:0] w,
        input logic [31:0] s, input logic [31:0] lo, input logic [31:0] hi);
        wr(k, s);
        wr(c, w | RUN);
        repeat (1000) @(posedge clk);
        wr(c, w);
        rng(nm, k, lo, hi);
    endtask
    // wait for core toggle (0) or compare clock (1) to reach v; n holds cycles
    task wt(input int s, input logic v);
        n = 0;
        while ((s == 0 ? ct : cmp) !== v && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) begin
            miscompares++;
            summarize;
        end
    endtask
    // main sequence
    initial begin
        {srst, psel, pen, pwr, pa, pwd, miscompares, compares} = {1'b1, 47'h0, 64'h0};
        repeat (2) @(posedge clk);
        srst <= 0;
        for (int a = 0; a < 'h38; a += 4) if (a < 'h14 || a > 'h1C) rd("reset", a[11:0], 0);
        wr(`GPT_CNT_CORE, 32'hFFFF_A5C3);
        rd("width", `GPT_CNT_CORE, 32'h0000_A5C3);
        rd("unmapped", 12'h07C, 32'h0);
        chk("slverr", 32'(er), 32'h1);
        $display("test registers done");
        rate("m1 rate", `GPT_CTL_CORE, `GPT_CNT_CORE, cw(0, 0, 0), 0, 19, 21);
        rate("prescale", `GPT_CTL_CORE, `GPT_CNT_CORE, cw(0, 1, 0), 0, 9, 11);
        rate("m2 rate", `GPT_CTL_SCORE, `GPT_CNT_SCORE, cw(0, 0, 0), 0, 49, 51);
        rate("down", `GPT_CTL_CORE, `GPT_CNT_CORE, cw(0, 0, 0) | DN, 100, 79, 81);
        gpt_pins_i.set_dir(1, 1'b1);
        rate("pin dir", `GPT_CTL_CORE, `GPT_CNT_CORE, cw(0, 0, 0) | DN | XD, 100, 119, 121);
        gpt_pins_i.set_pin(1, 1'b1);
        rate("gate open", `GPT_CTL_CORE, `GPT_CNT_CORE, cw(`GPT_MODE_GATE, 0, 0), 0, 19, 21);
        rate("gate shut", `GPT_CTL_CORE, `GPT_CNT_CORE, cw(`GPT_MODE_GATEN, 0, 0), 0, 0, 0);
        gpt_pins_i.set_pin(1, 1'b0);
        rate("gate low", `GPT_CTL_CORE, `GPT_CNT_CORE, cw(`GPT_MODE_GATEN, 0, 0), 0, 19, 21);
        $display("test rates done");
        wr(`GPT_CNT_CORE, 0);
        wr(`GPT_CTL_CORE, cw(`GPT_MODE_COUNT, 0, 1) | RUN);
        gpt_pins_i.pulse(1, 5);
        repeat (8) @(posedge clk);
        rd("counter", `GPT_CNT_CORE, 5);
        wr(`GPT_CTL_CORE, 0);
        wr(`GPT_FLAGS, 32'h3F);
        wr(`GPT_CNT_SAUX, 32'h0300);
        wr(`GPT_CTL_SAUX, cw(0, 0, 1) | CL);
        gpt_pins_i.pulse(5, 1);
        repeat (8) @(posedge clk);
        rd("capture_reload_reg", `GPT_CAPTURE_RELOAD_REG, 32'h0300);
        rd("aux cleared", `GPT_CNT_SAUX, 0);
        rd("capture flag", `GPT_FLAGS, 32'h20);
        wr(`GPT_CNT_CORE, 32'h0777);
        wr(`GPT_CTL_LOW, cw(`GPT_MODE_CAPTURE, 0, 1) | RUN);
        gpt_pins_i.pulse(0, 1);
        repeat (200) @(posedge clk);
        rd("aux capture", `GPT_CNT_LOW, 32'h0777);
        wr(`GPT_CNT_HIGH, 32'h4321);
        wr(`GPT_CTL_HIGH, cw(`GPT_MODE_RELOAD, 0, 1));
        gpt_pins_i.pulse(2, 1);
        repeat (8) @(posedge clk);
        rd("pin reload", `GPT_CNT_CORE, 32'h4321);
        $display("test capture done");
        wr(`GPT_FLAGS, 32'h3F);
        wr(`GPT_CNT_CORE, 32'hFFFF);
        wr(`GPT_CTL_CORE, cw(0, 0, 0) | RUN | OE);
        wt(0, 1'b1);
        repeat (4) @(posedge clk);
        chk("flag pins", 32'(flg), 32'h2);
        rd("core flag", `GPT_FLAGS, 32'h2);
        wr(`GPT_FLAGS, 32'h2);
        rd("flag clear", `GPT_FLAGS, 0);
        wr(`GPT_CNT_LOW, 32'hFFFD);
        wr(`GPT_CTL_LOW, cw(`GPT_MODE_RELOAD, 0, 2));
        wr(`GPT_CNT_HIGH, 32'hFFFB);
        wr(`GPT_CTL_HIGH, cw(`GPT_MODE_RELOAD, 0, 3));
        wr(`GPT_CNT_CORE, 32'hFFFF);
        wt(0, 1'b0);
        wt(0, 1'b1);
        chk("pwm low", 32'(n >= 245 && n <= 260), 32'h1);
        wt(0, 1'b0);
        chk("pwm high", 32'(n >= 145 && n <= 160), 32'h1);
        wr(`GPT_CTL_CORE, 0);
        wr(`GPT_CNT_HIGH, 32'hFFFF);
        wr(`GPT_CTL_HIGH, cw(0, 0, 0) | RUN | OE);
        repeat (60) @(posedge clk);
        chk("high toggle", 32'(ht), 32'h1);
        rd("latch status", `GPT_STATUS, 32'h2);
        $display("test toggle done");
        wr(`GPT_FLAGS, 32'h3F);
        wr(`GPT_CTL_SAUX, cw(`GPT_MODE_CONCAT, 0, 0) | RUN);
        wr(`GPT_CNT_SCORE, 32'hFFFF);
        wr(`GPT_CTL_SCORE, cw(0, 0, 0) | RUN | OE | RL);
        wt(1, 1'b1);
        repeat (2) @(posedge clk);
        chk("second toggle", 32'(st), 32'h1);
        wr(`GPT_CTL_SCORE, 0);
        rng("capture_reload_reg reload", `GPT_CNT_SCORE, 32'h0300, 32'h0301);
        rd("second flag", `GPT_FLAGS, 32'h10);
        rd("concat", `GPT_CNT_SAUX, 32'h1);
        $display("test second module done");
        summarize;
    end
endmodule
`default_nettype wire
